/* core/temp_sensor_defs.svh */
// Operation
// - Selector 0 temp high, 1 config, 2 lower limit, 3 upper limit, 4 temp low.
// - Temp high byte: sign bit in bit 7, next seven result bits below.
// - Temp low byte: four lowest result bits in 7:4, zeros in 3:0.
// - Results are two's complement; temperature reads zero until first conversion.
// - Config: id bit 7, rate 6:5, alarms 4 and 3, latch 2, mode 1:0.
// - Rate codes 00,01,10,11 give 0.25, 1, 4, 8 Hz continuous conversion.
// - Mode 00 shutdown, 01 one-shot, 1x continuous conversion.
// - Shutdown stops conversions while register access keeps working.
// - Writing 01 while shut down runs one conversion, then returns to shutdown.
// - Continuous mode starts conversions repeatedly at the selected rate.
// - Each finished result is compared with both limit registers.
// - High alarm sets when temp high byte exceeds upper limit.
// - Low alarm sets when temp high byte is below lower limit.
// - With latch select 0, a result between limits clears both alarm bits.
// - Latch select 0: alarms follow every new comparison result.
// - Latch select 1: alarms hold until a config read completes, then clear.
// - Reset limits: upper is +60 C code, lower is -10 C code.
// - Each limit is one signed byte aligned with the temp high byte.
// - Written values take effect only once the whole byte has arrived.
`ifndef TEMP_SENSOR_DEFS_SVH
`define TEMP_SENSOR_DEFS_SVH
`define SEL_TEMP_HIGH 3'h0
`define SEL_CONFIG 3'h1
`define SEL_LOWER 3'h2
`define SEL_UPPER 3'h3
`define SEL_TEMP_LOW 3'h4
`define CONFIG_RESET 8'h02
`define UPPER_RESET 8'h3c
`define LOWER_RESET 8'hf6
`define CFG_ID_BIT 7
`define CFG_HIGH_ALARM_BIT 4
`define CFG_LOW_ALARM_BIT 3
`define TICK_NS 125000000
`define CLK_NS 25
`define TICKS_RATE_0 8'h20
`define TICKS_RATE_1 8'h08
`define TICKS_RATE_2 8'h02
`define TICKS_RATE_3 8'h01
`endif

/* core/temp_sensor_pkg.sv */
package temp_sensor_pkg;
  typedef struct packed {
    logic top_config_bit;
    logic [1:0] rate_select;
    logic high_alarm_bit;
    logic low_alarm_bit;
    logic latch_select;
    logic [1:0] mode_select;
  } config_type;
  typedef struct packed {
    logic valid;
    logic [11:0] temp_code_bits;
  } conv_result_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT
  } conv_state_type;
endpackage : temp_sensor_pkg

/* core/temp_sensor_regs_and_alarm.sv */
`timescale 1ns/1ps
`include "temp_sensor_defs.svh"
module temp_sensor_regs_and_alarm #(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_NS,
  parameter logic ID_VALUE = 1'b0
)(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sel_wr,
  input wire logic i_data_wr,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_req,
  input wire logic i_rd_done,
  input wire temp_sensor_pkg::conv_result_type i_conv,
  output logic [7:0] o_rd_byte,
  output logic o_conv_start,
  output logic o_busy,
  output logic o_high_alarm,
  output logic o_low_alarm
);

  // ID_VALUE is arbitrary and only fills the top configuration bit.
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  logic [2:0] selector_reg;
  temp_sensor_pkg::config_type config_reg;
  logic [7:0] lower_limit_reg;
  logic [7:0] upper_limit_reg;
  logic [11:0] result_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic [7:0] rate_cnt_reg;
  logic [7:0] rate_ticks;
  temp_sensor_pkg::conv_state_type state_reg;
  logic oneshot_reg;
  logic done_s1_reg;
  logic done_s2_reg;
  logic done_s3_reg;
  logic [11:0] data_s1_reg;
  logic [11:0] data_s2_reg;
  logic done_pulse;
  logic finish;
  logic continuous;
  logic start;
  logic signed [7:0] temp_high;
  logic above;
  logic below;
  logic cfg_read_done;
  logic rd_sel_cfg_reg;

  // The converter runs off its own timing, so its done level and code pass two flops.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
      data_s1_reg <= 12'h000;
      data_s2_reg <= 12'h000;
    end
    else
    begin
      done_s1_reg <= i_conv.valid;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
      data_s1_reg <= i_conv.temp_code_bits;
      data_s2_reg <= data_s1_reg;
    end
  end

  // The code is taken from the same flop stage as its done edge, data_s2_reg beside done_s2_reg.
  assign done_pulse = done_s2_reg & ~done_s3_reg;
  assign finish = (state_reg == temp_sensor_pkg::ST_CONVERT) & done_pulse;

  // Selector is loaded only from a complete byte; bits above the low three are dropped.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      selector_reg <= `SEL_TEMP_HIGH;
    end
    else if (i_sel_wr)
    begin
      selector_reg <= i_wr_byte[2:0];
    end
  end

  // Limit registers are written whole bytes at a time.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      upper_limit_reg <= `UPPER_RESET;
      lower_limit_reg <= `LOWER_RESET;
    end
    else if (i_data_wr)
    begin
      if (selector_reg == `SEL_UPPER)
      begin
        upper_limit_reg <= i_wr_byte;
      end
      if (selector_reg == `SEL_LOWER)
      begin
        lower_limit_reg <= i_wr_byte;
      end
    end
  end

  // Configuration register: the host sets rate, latch and mode; the id bit is fixed.
  // The alarm bits live here as well, so the whole byte has one driving process.
  // A finished one-shot puts the mode back to shutdown, which outranks a host write.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      config_reg <= `CONFIG_RESET;
    end
    else
    begin
      config_reg.top_config_bit <= ID_VALUE;
      if (i_data_wr && selector_reg == `SEL_CONFIG)
      begin
        config_reg.rate_select <= i_wr_byte[6:5];
        config_reg.latch_select <= i_wr_byte[2];
        config_reg.mode_select <= i_wr_byte[1:0];
      end
      if (finish && oneshot_reg)
      begin
        config_reg.mode_select <= 2'h0;
      end
      // Only comparisons and the latched read-clear move the alarms; a set beats a clear.
      if (!config_reg.latch_select)
      begin
        if (finish)
        begin
          config_reg.high_alarm_bit <= above;
          config_reg.low_alarm_bit <= below;
        end
      end
      else
      begin
        config_reg.high_alarm_bit <= (finish & above)
                                     | (config_reg.high_alarm_bit & ~cfg_read_done);
        config_reg.low_alarm_bit <= (finish & below)
                                    | (config_reg.low_alarm_bit & ~cfg_read_done);
      end
    end
  end

  // A one-shot is armed only by writing 01 while the mode is shutdown.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      oneshot_reg <= 1'b0;
    end
    else if (i_data_wr && selector_reg == `SEL_CONFIG && i_wr_byte[1:0] == 2'h1
             && config_reg.mode_select == 2'h0)
    begin
      oneshot_reg <= 1'b1;
    end
    else if (finish || config_reg.mode_select != 2'h1)
    begin
      oneshot_reg <= 1'b0;
    end
  end

  // Eighth-second tick shared by all rates; one divider keeps the counter small.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tick_cnt_reg <= '0;
    end
    else if (tick)
    begin
      tick_cnt_reg <= '0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
  assign continuous = config_reg.mode_select[1];

  // Rate code to ticks between conversion starts.
  always_comb
  begin
    unique case (config_reg.rate_select)
      2'h0: rate_ticks = `TICKS_RATE_0;
      2'h1: rate_ticks = `TICKS_RATE_1;
      2'h2: rate_ticks = `TICKS_RATE_2;
      2'h3: rate_ticks = `TICKS_RATE_3;
    endcase
  end

  // Interval counter: zero means a start is due; it is cleared outside continuous mode.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rate_cnt_reg <= 8'h00;
    end
    else if (!continuous)
    begin
      rate_cnt_reg <= 8'h00;
    end
    else if (start)
    begin
      rate_cnt_reg <= rate_ticks;
    end
    else if (tick && rate_cnt_reg != 8'h00)
    begin
      rate_cnt_reg <= rate_cnt_reg - 8'h01;
    end
  end

  // A due start waits for the previous conversion, so a slow converter lowers the rate.
  assign start = (state_reg == temp_sensor_pkg::ST_IDLE)
                 & ((continuous & (rate_cnt_reg == 8'h00)) | oneshot_reg);

  // Conversion sequencer; shutdown abandons a conversion in flight.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg <= temp_sensor_pkg::ST_IDLE;
    end
    else
    begin
      unique case (state_reg)
        temp_sensor_pkg::ST_IDLE:
        begin
          if (start)
          begin
            state_reg <= temp_sensor_pkg::ST_CONVERT;
          end
        end
        temp_sensor_pkg::ST_CONVERT:
        begin
          if (done_pulse || (config_reg.mode_select == 2'h0 && !oneshot_reg))
          begin
            state_reg <= temp_sensor_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Start pulse to the converter is a flop so it is glitch free.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_conv_start <= 1'b0;
    end
    else
    begin
      o_conv_start <= start;
    end
  end

  assign o_busy = (state_reg == temp_sensor_pkg::ST_CONVERT);

  // Result holds zero until the first conversion lands.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      result_reg <= 12'h000;
    end
    else if (finish)
    begin
      result_reg <= data_s2_reg;
    end
  end

  // Compare the fresh high byte, signed, against both limits.
  assign temp_high = data_s2_reg[11:4];
  assign above = temp_high > $signed(upper_limit_reg);
  assign below = temp_high < $signed(lower_limit_reg);
  assign cfg_read_done = i_rd_done & rd_sel_cfg_reg;

  // Alarm outputs show the flags straight from the configuration register.
  assign o_high_alarm = config_reg.high_alarm_bit;
  assign o_low_alarm = config_reg.low_alarm_bit;

  // Read byte is captured on request and stays until the next request.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rd_byte <= 8'h00;
      rd_sel_cfg_reg <= 1'b0;
    end
    else if (i_rd_req)
    begin
      rd_sel_cfg_reg <= (selector_reg == `SEL_CONFIG);
      unique case (selector_reg)
        `SEL_TEMP_HIGH: o_rd_byte <= result_reg[11:4];
        `SEL_CONFIG: o_rd_byte <= config_reg;
        `SEL_LOWER: o_rd_byte <= lower_limit_reg;
        `SEL_UPPER: o_rd_byte <= upper_limit_reg;
        `SEL_TEMP_LOW: o_rd_byte <= {result_reg[3:0], 4'h0};
        default: o_rd_byte <= 8'h00;
      endcase
    end
  end

endmodule : temp_sensor_regs_and_alarm

/* tb/temp_sensor_checker.sv */
`timescale 1ns/1ps
// Port-level checks on conversion launch, alarm timing and read data.
module temp_sensor_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd_req,
  input wire logic i_rd_done,
  input wire logic [7:0] o_rd_byte,
  input wire logic o_conv_start,
  input wire logic o_busy,
  input wire logic o_high_alarm,
  input wire logic o_low_alarm
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // A result lands on the edge where busy drops.
  sequence s_done;
    $fell(o_busy);
  endsequence
  // A launch finds the sequencer busy already; a shutdown may abort it one cycle later.
  sequence s_launch;
    o_conv_start && o_busy;
  endsequence
  a_start_busy: assert property (o_conv_start |-> s_launch)
    else $error("start without busy");
  a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("start longer than one cycle");
  a_idle_start: assert property (o_conv_start |-> !$past(o_busy))
    else $error("start while busy");
  a_busy_cause: assert property ($rose(o_busy) |-> o_conv_start)
    else $error("busy without start");
  a_high_cause: assert property ($rose(o_high_alarm) |-> s_done)
    else $error("high alarm outside a result");
  a_low_cause: assert property ($rose(o_low_alarm) |-> s_done)
    else $error("low alarm outside a result");
  a_flag_clear: assert property (($fell(o_high_alarm) || $fell(o_low_alarm))
    |-> ($fell(o_busy) || $past(i_rd_done))) else $error("alarm cleared without cause");
  a_rd_hold: assert property (!i_rd_req |=> $stable(o_rd_byte))
    else $error("read data moved");
endmodule : temp_sensor_checker
bind temp_sensor_regs_and_alarm temp_sensor_checker i_temp_sensor_checker (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd_req(i_rd_req), .i_rd_done(i_rd_done),
  .o_rd_byte(o_rd_byte), .o_conv_start(o_conv_start), .o_busy(o_busy),
  .o_high_alarm(o_high_alarm), .o_low_alarm(o_low_alarm));

/* tb/temp_conv_model.sv */
`timescale 1ns/1ps
// Converter stand-in: each start gives one done edge some cycles later.
module temp_conv_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [11:0] i_code,
  output temp_sensor_pkg::conv_result_type o_conv
);
  logic [3:0] step_reg = 4'h0;
  // The step count wraps to zero after fifteen cycles, so valid falls by itself.
  always @(posedge i_clk)
  begin
    if (i_start)
      step_reg <= 4'h1;
    else if (step_reg != 4'h0)
      step_reg <= step_reg + 4'h1;
  end
  // The code is only promised around done; while the step count is zero it shows the inverse.
  assign o_conv = {step_reg >= 4'h8, (step_reg != 4'h0) ? i_code : ~i_code};
endmodule : temp_conv_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst;
  logic sel_wr;
  logic data_wr;
  logic rd_req;
  logic rd_done;
  logic [7:0] wr_byte;
  logic [11:0] code;
  temp_sensor_pkg::conv_result_type conv;
  logic [7:0] rd_byte;
  logic start;
  logic busy;
  logic hi;
  logic lo;
  int num_errors = 0;
  int n_compared = 0;
  // Clock at 40 MHz.
  always #12.5 clk = ~clk;
  // A short tick keeps the rate intervals within a few thousand cycles.
  temp_sensor_regs_and_alarm #(.TICK_CYCLES(20)) i_temp_sensor_regs_and_alarm (
    .i_clk(clk), .i_sys_rst(rst), .i_sel_wr(sel_wr), .i_data_wr(data_wr),
    .i_wr_byte(wr_byte), .i_rd_req(rd_req), .i_rd_done(rd_done), .i_conv(conv),
    .o_rd_byte(rd_byte), .o_conv_start(start), .o_busy(busy), .o_high_alarm(hi),
    .o_low_alarm(lo));
  temp_conv_model i_temp_conv_model (.i_clk(clk), .i_start(start), .i_code(code),
    .o_conv(conv));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bus helpers: one-cycle strobes launched on falling edges.
  task automatic select(input logic [7:0] s);
    @(negedge clk);
    sel_wr = 1'b1;
    wr_byte = s;
    @(negedge clk);
    sel_wr = 1'b0;
  endtask : select
  task automatic wr(input logic [7:0] d);
    data_wr = 1'b1;
    wr_byte = d;
    @(negedge clk);
    data_wr = 1'b0;
  endtask : wr
  task automatic rd(input string what, input logic [7:0] s, input logic [7:0] exp);
    select(s);
    rd_req = 1'b1;
    @(negedge clk);
    rd_req = 1'b0;
    chk(what, exp, rd_byte);
    rd_done = 1'b1;
    @(negedge clk);
    rd_done = 1'b0;
  endtask : rd
  task automatic wait_done();
    int k;
    k = 0;
    while (!busy && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    chk("busy", 8'h01, {7'h0, busy});
    while (busy && k < 80)
    begin
      @(negedge clk);
      k++;
    end
    chk("done", 8'h00, {7'h0, busy});
  endtask : wait_done
  task automatic conv1(input logic [11:0] c, input logic [7:0] cfg);
    code = c;
    select(8'h01);
    wr(cfg);
    wait_done();
  endtask : conv1
  task automatic oneshot(input logic [11:0] c, input logic he, input logic le);
    conv1(c, 8'h01);
    chk("high alarm", {7'h0, he}, {7'h0, hi});
    chk("low alarm", {7'h0, le}, {7'h0, lo});
    rd("config", 8'h01, {3'h0, he, le, 3'h0});
    rd("temp high", 8'h00, c[11:4]);
    rd("temp low", 8'h04, {c[3:0], 4'h0});
  endtask : oneshot
  task automatic wait_start(output int k);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (!start && k < 2000);
  endtask : wait_start
  task automatic t_reset();
    rd("temp high", 8'h00, 8'h00);
    rd("temp low", 8'h04, 8'h00);
    rd("config", 8'h01, 8'h02);
    rd("lower", 8'h02, 8'hf6);
    rd("upper", 8'h03, 8'h3c);
  endtask : t_reset
  task automatic t_shutdown();
    int k;
    int n;
    n = 0;
    select(8'h01);
    wr(8'h00);
    for (k = 0; k < 80; k++)
    begin
      @(negedge clk);
      n += start;
    end
    chk("starts", 8'h00, n[7:0]);
    chk("busy", 8'h00, {7'h0, busy});
    rd("config", 8'h01, 8'h00);
  endtask : t_shutdown
  task automatic t_compare();
    oneshot(12'h3d7, 1'b1, 1'b0);
    oneshot(12'hf50, 1'b0, 1'b1);
    oneshot(12'h190, 1'b0, 1'b0);
    oneshot(12'h3c5, 1'b0, 1'b0);
    oneshot(12'hf60, 1'b0, 1'b0);
  endtask : t_compare
  // Latched flags must survive a quiet result and a config write.
  task automatic t_latch();
    conv1(12'h3d0, 8'h05);
    conv1(12'h190, 8'h1d);
    chk("held high", 8'h01, {7'h0, hi});
    chk("low kept", 8'h00, {7'h0, lo});
    rd("config", 8'h01, 8'h14);
    chk("cleared", 8'h00, {7'h0, hi});
  endtask : t_latch
  task automatic t_access();
    select(8'h00);
    wr(8'h55);
    rd("temp high", 8'h00, 8'h19);
    select(8'h03);
    wr(8'h7f);
    rd("upper", 8'h03, 8'h7f);
    select(8'h02);
    wr(8'h80);
    rd("lower", 8'h02, 8'h80);
    rd("unmapped", 8'h05, 8'h00);
  endtask : t_access
  // Gap between later starts; the first interval after a rate change may differ.
  task automatic t_rates();
    int gap;
    int n;
    logic [1:0] r;
    for (int i = 0; i < 4; i++)
    begin
      r = i[1:0];
      n = (i == 0) ? 32 : (i == 1) ? 8 : (i == 2) ? 2 : 1;
      select(8'h01);
      wr({1'b0, r, 3'h0, 1'b1, r[0]});
      wait_start(gap);
      wait_start(gap);
      wait_start(gap);
      chk("rate gap", 8'h01, {7'h0, gap >= n * 20 - 20 && gap <= n * 20 + 4});
    end
    select(8'h01);
    wr(8'h00);
  endtask : t_rates
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // Watchdog well beyond the expected run length.
  initial
  begin
    #500000;
    num_errors++;
    final_report();
  end
  initial
  begin
    rst = 1'b1;
    {sel_wr, data_wr, rd_req, rd_done} = 4'h0;
    wr_byte = 8'h00;
    code = 12'h000;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_shutdown();
    t_compare();
    t_latch();
    t_access();
    t_rates();
    final_report();
  end
endmodule : tb
